// ### hdl/its_pkg.sv
/*
  its_pkg: register map, status bit layout, reset values, timing counts
  and state types shared by the i2c slave with bus time-out and its
  i2c master far end.
  assumes: a single 40 MHz system clock on both ends.
*/
package its_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ      = 40_000_000;
  localparam int SUB_HZ      = 32_768;
  localparam int SUB_DIV     = CLK_HZ / SUB_HZ;
  localparam int TO_PRESCALE = 32;
  localparam int SCL_HZ      = 100_000;
  localparam int SCL_QTR     = CLK_HZ / (4 * SCL_HZ);

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [2:0] OFS_DATA   = 3'h0;
  localparam logic [2:0] OFS_ADDR   = 3'h1;
  localparam logic [2:0] OFS_MODE   = 3'h2;
  localparam logic [2:0] OFS_STATUS = 3'h3;
  localparam logic [2:0] OFS_TOC    = 3'h4;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int ST_BYTE_DONE = 7;
  localparam int ST_MATCH     = 6;
  localparam int ST_BUSY      = 5;
  localparam int ST_TX_SEL    = 4;
  localparam int ST_TX_ACK    = 3;
  localparam int ST_DIR       = 2;
  localparam int ST_WAKE      = 1;
  localparam int ST_RX_ACK    = 0;
  localparam int MODE_EN  = 1;
  localparam int TOC_EN   = 7;
  localparam int TOC_FLAG = 6;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] DATA_POR   = 8'h00;
  localparam logic [7:0] ADDR_POR   = 8'h00;
  localparam logic [7:0] MODE_POR   = 8'he0;
  localparam logic [7:0] STATUS_POR = 8'h81;
  localparam logic [7:0] TOC_POR    = 8'h00;
  localparam logic [7:0] STATUS_WMASK = 8'h1a;

  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    SS_IDLE, SS_ADDR, SS_AACK, SS_HOLD, SS_TX, SS_MACK, SS_RX, SS_SACK, SS_WAIT
  } its_sst_t;

  typedef enum logic [1:0] {
    MS_IDLE, MS_START, MS_BIT, MS_STOP
  } its_mst_t;
endpackage : its_pkg

// ### hdl/its_if.sv
/*
  its_if: open-drain i2c wires between slave and master ends.
  assumes: each party drives low only; an idle line reads high.
*/
`timescale 1ns/1ps
`default_nettype none
interface its_if;
  // ----------------------------------------------------------------
  // drivers and resolved levels
  // ----------------------------------------------------------------
  logic slv_scl_o;
  logic slv_scl_oe;
  logic slv_sda_o;
  logic slv_sda_oe;
  logic mst_scl_o;
  logic mst_scl_oe;
  logic mst_sda_o;
  logic mst_sda_oe;
  logic scl;
  logic sda;

  assign scl = ~((slv_scl_oe & ~slv_scl_o) | (mst_scl_oe & ~mst_scl_o));
  assign sda = ~((slv_sda_oe & ~slv_sda_o) | (mst_sda_oe & ~mst_sda_o));

  modport slave  (input scl, sda, output slv_scl_o, slv_scl_oe, slv_sda_o, slv_sda_oe);
  modport master (input scl, sda, output mst_scl_o, mst_scl_oe, mst_sda_o, mst_sda_oe);
endinterface : its_if
`default_nettype wire

// ### hdl/its_slave.sv
/*
  its_slave: i2c slave engine with clock stretching, software register
  port and bus time-out counter run from a divided sub clock.
  assumes: scl/sda synchronous to clk; software serves each irq pulse.
*/
`timescale 1ns/1ps
`default_nettype none
module its_slave
  import its_pkg::*;
#(
  parameter int SUB_DIV_P = SUB_DIV
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  // register port
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output var  logic [7:0] reg_rdata,
  // event
  output var  logic       irq,
  // i2c
  its_if.slave            bus
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    its_sst_t    st;
    logic        scl_q;
    logic        sda_q;
    logic [3:0]  bitn;
    logic [7:0]  sh;
    logic [7:0]  data;
    logic [7:0]  addr;
    logic [7:0]  mode;
    logic [7:0]  stat;
    logic [7:0]  toc;
    logic        toact;
    logic [5:0]  tocnt;
    logic [15:0] subc;
    logic [4:0]  div32;
    logic        scl_oe;
    logic        sda_oe;
    logic        irq;
    logic [7:0]  rdata;
  } its_sl_t;

  its_sl_t q_r;
  its_sl_t q_nxt;

  localparam logic [15:0] SUB_LAST = 16'(SUB_DIV_P - 1);
  localparam logic [4:0]  PRE_LAST = 5'(TO_PRESCALE - 1);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic rise;
    logic fall;
    logic start;
    logic stop;
    logic sub_tick;
    logic to_tick;
    logic [7:0] shin;
    q_nxt    = q_r;
    rise     = bus.scl & ~q_r.scl_q;
    fall     = ~bus.scl & q_r.scl_q;
    start    = q_r.scl_q & bus.scl & q_r.sda_q & ~bus.sda;
    stop     = q_r.scl_q & bus.scl & ~q_r.sda_q & bus.sda;
    sub_tick = (q_r.subc == SUB_LAST);
    to_tick  = sub_tick & (q_r.div32 == PRE_LAST);
    shin     = {q_r.sh[6:0], bus.sda};
    q_nxt.irq   = 1'b0;
    q_nxt.scl_q = bus.scl;
    q_nxt.sda_q = bus.sda;
    q_nxt.subc  = sub_tick ? 16'h0000 : q_r.subc + 16'h0001;
    if (sub_tick)
    begin
      q_nxt.div32 = q_r.div32 + 5'h01;
    end

    // register port
    if (reg_rd)
    begin
      unique case (reg_addr)
        OFS_DATA:   q_nxt.rdata = q_r.data;
        OFS_ADDR:   q_nxt.rdata = q_r.addr;
        OFS_MODE:   q_nxt.rdata = q_r.mode;
        OFS_STATUS: q_nxt.rdata = q_r.stat;
        OFS_TOC:    q_nxt.rdata = q_r.toc;
        default:    q_nxt.rdata = 8'h00;
      endcase
    end
    if (reg_wr)
    begin
      unique case (reg_addr)
        OFS_DATA:   q_nxt.data = reg_wdata;
        OFS_ADDR:   q_nxt.addr = reg_wdata;
        OFS_MODE:   q_nxt.mode = reg_wdata;
        OFS_STATUS: q_nxt.stat = (q_r.stat & ~STATUS_WMASK) | (reg_wdata & STATUS_WMASK);
        OFS_TOC:    q_nxt.toc  = reg_wdata;
        default:    ;
      endcase
    end

    // protocol
    unique case (q_r.st)
      SS_IDLE, SS_WAIT:
        q_nxt.st = q_r.st;
      SS_ADDR:
      begin
        if (rise)
        begin
          q_nxt.sh   = shin;
          q_nxt.bitn = q_r.bitn + 4'h1;
        end
        else if (fall && q_r.bitn == 4'h8)
        begin
          if (q_r.sh[7:1] == q_r.addr[6:0])
          begin
            q_nxt.stat[ST_DIR]   = q_r.sh[0];
            q_nxt.stat[ST_MATCH] = 1'b1;
            q_nxt.irq    = 1'b1;
            q_nxt.sda_oe = 1'b1;
            q_nxt.toact  = 1'b1;
            q_nxt.tocnt  = 6'h00;
            q_nxt.st     = SS_AACK;
          end
          else
          begin
            q_nxt.st = SS_WAIT;
          end
        end
      end
      SS_AACK:
        if (fall)
        begin
          q_nxt.sda_oe = 1'b0;
          q_nxt.scl_oe = 1'b1;
          q_nxt.st     = SS_HOLD;
        end
      SS_HOLD:
        if (q_r.stat[ST_TX_SEL] && reg_wr && reg_addr == OFS_DATA)
        begin
          q_nxt.sh     = reg_wdata;
          q_nxt.sda_oe = ~reg_wdata[7];
          q_nxt.bitn   = 4'h0;
          q_nxt.stat[ST_BYTE_DONE] = 1'b0;
          q_nxt.stat[ST_MATCH]     = 1'b0;
          q_nxt.st     = SS_TX;
        end
        else if (!q_r.stat[ST_TX_SEL] && reg_rd && reg_addr == OFS_DATA)
        begin
          q_nxt.scl_oe = 1'b0;
          q_nxt.bitn   = 4'h0;
          q_nxt.stat[ST_BYTE_DONE] = 1'b0;
          q_nxt.stat[ST_MATCH]     = 1'b0;
          q_nxt.st     = SS_RX;
        end
      SS_TX:
        // first bit settles on sda one clock before scl is let go
        if (q_r.scl_oe)
        begin
          q_nxt.scl_oe = 1'b0;
        end
        else if (fall)
        begin
          q_nxt.bitn = q_r.bitn + 4'h1;
          if (q_r.bitn == 4'h7)
          begin
            q_nxt.sda_oe = 1'b0;
            q_nxt.st     = SS_MACK;
          end
          else
          begin
            q_nxt.sh     = {q_r.sh[6:0], 1'b0};
            q_nxt.sda_oe = ~q_r.sh[6];
          end
        end
      SS_MACK:
        if (rise)
        begin
          q_nxt.stat[ST_RX_ACK] = bus.sda;
        end
        else if (fall)
        begin
          q_nxt.stat[ST_BYTE_DONE] = 1'b1;
          q_nxt.irq = 1'b1;
          if (!q_r.stat[ST_RX_ACK])
          begin
            q_nxt.scl_oe = 1'b1;
            q_nxt.st     = SS_HOLD;
          end
          else
          begin
            q_nxt.st = SS_WAIT;
          end
        end
      SS_RX:
        if (rise)
        begin
          q_nxt.sh   = shin;
          q_nxt.bitn = q_r.bitn + 4'h1;
          if (q_r.bitn == 4'h7)
          begin
            q_nxt.data = shin;
          end
        end
        else if (fall && q_r.bitn == 4'h8)
        begin
          q_nxt.sda_oe = ~q_r.stat[ST_TX_ACK];
          q_nxt.st     = SS_SACK;
        end
      SS_SACK:
        if (fall)
        begin
          q_nxt.sda_oe = 1'b0;
          q_nxt.scl_oe = 1'b1;
          q_nxt.stat[ST_BYTE_DONE] = 1'b1;
          q_nxt.irq = 1'b1;
          q_nxt.st  = SS_HOLD;
        end
    endcase

    // bus conditions
    if (start)
    begin
      q_nxt.stat[ST_BUSY] = 1'b1;
      q_nxt.st     = SS_ADDR;
      q_nxt.bitn   = 4'h0;
      q_nxt.sda_oe = 1'b0;
      q_nxt.scl_oe = 1'b0;
    end
    else if (stop)
    begin
      q_nxt.stat[ST_BUSY] = 1'b0;
      q_nxt.st     = SS_IDLE;
      q_nxt.sda_oe = 1'b0;
      q_nxt.scl_oe = 1'b0;
      q_nxt.toact  = 1'b0;
    end

    // time-out
    if (fall)
    begin
      q_nxt.tocnt = 6'h00;
    end
    else if (q_r.toact && !stop && q_r.toc[TOC_EN] && to_tick)
    begin
      if (q_r.tocnt == q_r.toc[5:0])
      begin
        q_nxt.toact         = 1'b0;
        q_nxt.toc[TOC_EN]   = 1'b0;
        q_nxt.toc[TOC_FLAG] = 1'b1;
        q_nxt.irq    = 1'b1;
        q_nxt.stat   = STATUS_POR;
        q_nxt.st     = SS_IDLE;
        q_nxt.sda_oe = 1'b0;
        q_nxt.scl_oe = 1'b0;
      end
      else
      begin
        q_nxt.tocnt = q_r.tocnt + 6'h01;
      end
    end

    // interface disabled
    if (!q_r.mode[MODE_EN])
    begin
      q_nxt.st     = SS_IDLE;
      q_nxt.sda_oe = 1'b0;
      q_nxt.scl_oe = 1'b0;
      q_nxt.toact  = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      q_r        <= '0;
      q_r.st     <= SS_IDLE;
      q_r.scl_q  <= 1'b1;
      q_r.sda_q  <= 1'b1;
      q_r.data   <= DATA_POR;
      q_r.addr   <= ADDR_POR;
      q_r.mode   <= MODE_POR;
      q_r.stat   <= STATUS_POR;
      q_r.toc    <= TOC_POR;
    end
    else
    begin
      q_r <= q_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign reg_rdata      = q_r.rdata;
  assign irq            = q_r.irq;
  assign bus.slv_scl_o  = 1'b0;
  assign bus.slv_sda_o  = 1'b0;
  assign bus.slv_scl_oe = q_r.scl_oe;
  assign bus.slv_sda_oe = q_r.sda_oe;
endmodule : its_slave
`default_nettype wire

// ### hdl/its_master.sv
/*
  its_master: i2c master far end; one address phase and one data byte
  per command, honouring slave clock stretching.
  assumes: one slave on the bus; commands only while idle.
*/
`timescale 1ns/1ps
`default_nettype none
module its_master
  import its_pkg::*;
#(
  parameter int QTR_P = SCL_QTR
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  // command
  input  wire logic       cmd_go,
  input  wire logic [6:0] cmd_addr,
  input  wire logic       cmd_rw,
  input  wire logic [7:0] cmd_wdata,
  // result
  output var  logic       busy,
  output var  logic       done,
  output var  logic       nack,
  output var  logic [7:0] rdata,
  // i2c
  its_if.master           bus
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    its_mst_t    st;
    logic [1:0]  ph;
    logic [15:0] div;
    logic [3:0]  bitn;
    logic        frame;
    logic [7:0]  sh;
    logic        rw;
    logic [7:0]  wbyte;
    logic        ackb;
    logic        nack;
    logic [7:0]  rdata;
    logic        scl_oe;
    logic        sda_oe;
    logic        done;
  } its_ms_t;

  its_ms_t q_r;
  its_ms_t q_nxt;

  localparam logic [15:0] QTR_LAST = 16'(QTR_P - 1);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic tick;
    logic rx_bit;
    q_nxt      = q_r;
    q_nxt.done = 1'b0;
    tick       = (q_r.div == QTR_LAST);
    rx_bit     = q_r.frame & q_r.rw;
    q_nxt.div  = (tick || q_r.st == MS_IDLE) ? 16'h0000 : q_r.div + 16'h0001;
    unique case (q_r.st)
      MS_IDLE:
        if (cmd_go)
        begin
          q_nxt.st    = MS_START;
          q_nxt.ph    = 2'h0;
          q_nxt.rw    = cmd_rw;
          q_nxt.wbyte = cmd_wdata;
          q_nxt.sh    = {cmd_addr, cmd_rw};
          q_nxt.frame = 1'b0;
          q_nxt.bitn  = 4'h0;
        end
      MS_START:
        if (tick)
        begin
          q_nxt.ph = q_r.ph + 2'h1;
          if (q_r.ph == 2'h1)
          begin
            q_nxt.sda_oe = 1'b1;
          end
          else if (q_r.ph == 2'h2)
          begin
            q_nxt.scl_oe = 1'b1;
            q_nxt.st     = MS_BIT;
            q_nxt.ph     = 2'h0;
          end
        end
      MS_BIT:
        if (tick)
        begin
          unique case (q_r.ph)
            2'h0:
            begin
              q_nxt.sda_oe = (q_r.bitn == 4'h8 || rx_bit) ? 1'b0 : ~q_r.sh[7];
              q_nxt.ph     = 2'h1;
            end
            2'h1:
            begin
              q_nxt.scl_oe = 1'b0;
              q_nxt.ph     = 2'h2;
            end
            2'h2:
              if (bus.scl)
              begin
                if (q_r.bitn == 4'h8)
                begin
                  q_nxt.ackb = bus.sda;
                end
                else
                begin
                  q_nxt.sh = {q_r.sh[6:0], bus.sda};
                end
                q_nxt.ph = 2'h3;
              end
            2'h3:
            begin
              q_nxt.scl_oe = 1'b1;
              q_nxt.ph     = 2'h0;
              q_nxt.bitn   = q_r.bitn + 4'h1;
              if (q_r.bitn == 4'h8)
              begin
                q_nxt.bitn = 4'h0;
                if (!q_r.frame && !q_r.ackb)
                begin
                  q_nxt.frame = 1'b1;
                  q_nxt.sh    = q_r.rw ? 8'hff : q_r.wbyte;
                end
                else
                begin
                  q_nxt.nack  = q_r.ackb & ~rx_bit;
                  q_nxt.rdata = q_r.sh;
                  q_nxt.st    = MS_STOP;
                end
              end
            end
          endcase
        end
      MS_STOP:
        if (tick)
        begin
          unique case (q_r.ph)
            2'h0:
            begin
              q_nxt.sda_oe = 1'b1;
              q_nxt.ph     = 2'h1;
            end
            2'h1:
            begin
              q_nxt.scl_oe = 1'b0;
              q_nxt.ph     = 2'h2;
            end
            2'h2:
              if (bus.scl)
              begin
                q_nxt.ph = 2'h3;
              end
            2'h3:
            begin
              q_nxt.sda_oe = 1'b0;
              q_nxt.done   = 1'b1;
              q_nxt.st     = MS_IDLE;
              q_nxt.ph     = 2'h0;
            end
          endcase
        end
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      q_r    <= '0;
      q_r.st <= MS_IDLE;
    end
    else
    begin
      q_r <= q_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign busy           = (q_r.st != MS_IDLE);
  assign done           = q_r.done;
  assign nack           = q_r.nack;
  assign rdata          = q_r.rdata;
  assign bus.mst_scl_o  = 1'b0;
  assign bus.mst_sda_o  = 1'b0;
  assign bus.mst_scl_oe = q_r.scl_oe;
  assign bus.mst_sda_oe = q_r.sda_oe;
endmodule : its_master
`default_nettype wire

// ### verif/its_properties.sv
/*
  its_properties: wire checks between the slave and master ends.
  assumes: instantiated beside the its_if instance, one clock.
*/
`timescale 1ns/1ps
`default_nettype none
module its_properties (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // resolved wires
  input wire logic scl,
  input wire logic sda,
  // pull-down enables
  input wire logic slv_scl_oe,
  input wire logic slv_sda_oe,
  input wire logic mst_scl_oe,
  input wire logic mst_sda_oe
);
  localparam int STRETCH_MAX = 700;
  logic [15:0] stretch_r;

  default clocking dcb @(posedge clk);
  endclocking
  default disable iff (srst);

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst || !slv_scl_oe)
      stretch_r <= 16'h0000;
    else
      stretch_r <= stretch_r + 16'h0001;
  end

  sequence start_s;
    scl && $past(scl) && $fell(sda);
  endsequence
  sequence stop_s;
    scl && $past(scl) && $rose(sda);
  endsequence

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  a_rst_release: assert property ($fell(srst) |-> !slv_scl_oe && !slv_sda_oe && !mst_scl_oe && !mst_sda_oe)
    else $error("bus not released after reset");
  a_sda_scl_low: assert property ($changed(slv_sda_oe) |-> !scl)
    else $error("slave moved sda while scl high");
  a_stretch_on_low: assert property ($rose(slv_scl_oe) |-> !$past(scl))
    else $error("stretch began while scl high");
  a_ack_held: assert property ($rose(slv_sda_oe) |=> slv_sda_oe [*3])
    else $error("slave low bit too short");
  a_stretch_bound: assert property (stretch_r < STRETCH_MAX)
    else $error("stretch never released");
  a_stop_quiet: assert property (stop_s |-> ##1 (!slv_sda_oe) [*8])
    else $error("slave drove sda after stop");
  a_mst_start: assert property (start_s and mst_sda_oe |-> ##[2:6] mst_scl_oe)
    else $error("master start not followed by scl low");
  a_stop_free: assert property ($fell(mst_sda_oe) && scl |-> !slv_sda_oe)
    else $error("slave held sda at stop");
endmodule : its_properties
`default_nettype wire

// ### verif/testbench.sv
/*
  testbench: slave and master joined over its_if, software served here.
  assumes: SUB_DIV_P 2 (tick 64 clk), QTR_P 4.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import its_pkg::*;
  logic       clk = 1'b0;
  logic       srst = 1'b1;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic       irq;
  logic       cmd_go = 1'b0;
  logic [6:0] cmd_addr = 7'h00;
  logic       cmd_rw = 1'b0;
  logic [7:0] cmd_wdata = 8'h00;
  logic       busy;
  logic       done;
  logic       nack;
  logic [7:0] rdata;
  logic [7:0] d;
  logic [7:0] por [6];
  int         err_total = 0;
  int         comparisons = 0;
  int         irq_cnt = 0;
  int         done_cnt = 0;
  int         nirq = 0;
  int         ndone = 0;
  int         cycles = 0;
  int         t0;

  its_if bus_if ();
  its_slave #(.SUB_DIV_P(2)) its_slave_i (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .bus(bus_if));
  its_master #(.QTR_P(4)) its_master_i (.clk(clk), .srst(srst), .cmd_go(cmd_go), .cmd_addr(cmd_addr),
    .cmd_rw(cmd_rw), .cmd_wdata(cmd_wdata), .busy(busy), .done(done), .nack(nack), .rdata(rdata), .bus(bus_if));
  its_properties its_properties_i (.clk(clk), .srst(srst), .scl(bus_if.scl), .sda(bus_if.sda),
    .slv_scl_oe(bus_if.slv_scl_oe), .slv_sda_oe(bus_if.slv_sda_oe), .mst_scl_oe(bus_if.mst_scl_oe),
    .mst_sda_oe(bus_if.mst_sda_oe));

  always #12.5 clk = ~clk;

  // ------------------------------------------------------------------
  // event counters and hang guard
  // ------------------------------------------------------------------
  always @(posedge clk)
  begin
    cycles++;
    if (irq === 1'b1)
      irq_cnt++;
    if (done === 1'b1)
      done_cnt++;
    if (cycles == 30000)
    begin
      err_total++;
      finish_test();
    end
  end

  // ------------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask : rd

  task automatic rchk(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
    rd(a);
    chk(d & m, e);
  endtask : rchk

  task automatic await_cnt(ref int cnt, input int target);
    int k;
    k = 0;
    while (cnt < target && k < 3000)
    begin
      @(negedge clk);
      k++;
    end
    chk(8'(cnt >= target), 8'h01);
  endtask : await_cnt

  task automatic wait_irq();
    nirq++;
    await_cnt(irq_cnt, nirq);
  endtask : wait_irq

  task automatic wait_done();
    ndone++;
    await_cnt(done_cnt, ndone);
  endtask : wait_done

  // match irq comes at the ack bit; stretch starts when it ends
  task automatic wait_match();
    wait_irq();
    repeat (24) @(posedge clk);
  endtask : wait_match

  task automatic go(input logic [6:0] a, input logic rw, input logic [7:0] w);
    @(posedge clk);
    cmd_addr <= a;
    cmd_rw <= rw;
    cmd_wdata <= w;
    cmd_go <= 1'b1;
    @(posedge clk);
    cmd_go <= 1'b0;
  endtask : go

  task automatic finish_test();
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : finish_test

  // ------------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------------
  initial
  begin
    por = '{DATA_POR, ADDR_POR, MODE_POR, STATUS_POR, TOC_POR, 8'h00};
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    wr(3'h5, 8'hff);
    for (int i = 0; i < 6; i++)
      rchk(3'(i), 8'hff, por[i]);
    wr(OFS_STATUS, 8'hff);
    rchk(OFS_STATUS, 8'hff, STATUS_POR | STATUS_WMASK);
    wr(OFS_STATUS, 8'h00);
    wr(OFS_ADDR, 8'h5a);
    // interface still disabled: nobody answers
    go(7'h5a, 1'b0, 8'h00);
    wait_done();
    chk(8'(nack), 8'h01);
    wr(OFS_MODE, 8'he2);
    wr(OFS_TOC, 8'h85);
    // write one byte, time-out armed but stop ends it
    go(7'h5a, 1'b0, 8'ha5);
    wait_match();
    chk(8'(busy), 8'h01);
    rchk(OFS_STATUS, 8'h64, 8'h60);
    rd(OFS_DATA);
    wait_irq();
    rchk(OFS_STATUS, 8'hc0, 8'h80);
    rchk(OFS_DATA, 8'hff, 8'ha5);
    wait_done();
    chk(8'(nack), 8'h00);
    rchk(OFS_STATUS, 8'h20, 8'h00);
    repeat (500) @(posedge clk);
    rchk(OFS_TOC, 8'hff, 8'h85);
    // receiver refuses the byte
    wr(OFS_STATUS, 8'h08);
    go(7'h5a, 1'b0, 8'h3c);
    wait_match();
    rd(OFS_DATA);
    wait_irq();
    rchk(OFS_DATA, 8'hff, 8'h3c);
    wait_done();
    chk(8'(nack), 8'h01);
    wr(OFS_STATUS, 8'h00);
    // master read, master ends with no ack
    go(7'h5a, 1'b1, 8'h00);
    wait_match();
    rchk(OFS_STATUS, 8'h04, 8'h04);
    wr(OFS_STATUS, 8'h10);
    wr(OFS_DATA, 8'hc3);
    wait_irq();
    rchk(OFS_STATUS, 8'h81, 8'h81);
    wait_done();
    chk(rdata, 8'hc3);
    chk(8'(nack), 8'h00);
    wr(OFS_STATUS, 8'h00);
    // last address bit differs
    go(7'h5b, 1'b0, 8'h00);
    wait_done();
    chk(8'(nack), 8'h01);
    chk(8'(irq_cnt - nirq), 8'h00);
    // stretch left unserved until time-out
    wr(OFS_TOC, 8'h83);
    go(7'h5a, 1'b0, 8'h77);
    wait_irq();
    t0 = cycles;
    wait_irq();
    chk(8'((cycles - t0) >= 190 && (cycles - t0) <= 340), 8'h01);
    wait_done();
    rchk(OFS_TOC, 8'hff, 8'h43);
    rchk(OFS_STATUS, 8'hff, STATUS_POR);
    rchk(OFS_ADDR, 8'hff, 8'h5a);
    rchk(OFS_MODE, 8'hff, 8'he2);
    wr(OFS_TOC, 8'h00);
    rchk(OFS_TOC, 8'hff, 8'h00);
    finish_test();
  end
endmodule : testbench
`default_nettype wire
